//--- include/bridge_b_wp_params.svh
/*
 * Offsets, reset values, field positions and widths of the write-protect
 * register block for bridge instance B.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef BRIDGE_B_WP_PARAMS_SVH
`define BRIDGE_B_WP_PARAMS_SVH

// Decoded address width on the register bus
`define WP_ADDR_W          12
`define WP_DATA_W          32
`define WP_PROT_W          7
`define WP_EVT_W           3

// Register byte offsets
`define WP_OFS_CLEAR       12'h000
`define WP_OFS_SET         12'h004
`define WP_OFS_IRQ_STATUS  12'h008
`define WP_OFS_IRQ_CLEAR   12'h00c
`define WP_OFS_IRQ_ENABLE  12'h010

// Protection field: reset value and implemented bits 6..1
`define WP_PROT_RESET      7'h02
`define WP_PROT_IMPL       7'h7e

// Protection bit positions
`define WP_BIT_TRACE       6
`define WP_BIT_USB         5
`define WP_BIT_DMA         4
`define WP_BIT_IO_PORT     3
`define WP_BIT_FLASH       2
`define WP_BIT_DEBUG_SVC   1

// Event bit positions in the interrupt registers
`define WP_EVT_DOUBLE_SET  0
`define WP_EVT_DOUBLE_CLR  1
`define WP_EVT_BLOCKED     2
`define WP_EVT_RESET       3'h0

// AHB-Lite encodings
`define WP_HSIZE_BYTE      3'h0
`define WP_HSIZE_HALF      3'h1

`endif

//--- include/bridge_b_wp_pkg.sv
/*
 * Types of the write-protect register block: guard request carrier and
 * the block's whole state as one packed struct.
 * Assumes the params header is on the include path.
 */
`default_nettype none

`include "bridge_b_wp_params.svh"

package bridge_b_wp_pkg;

    // Write attempts towards the guarded peripherals, one bit per position
    typedef struct packed {
        logic [`WP_PROT_W-1:0] write;
        logic                  debug;
    } guard_req_t;

    typedef struct packed {
        logic                  data_phase;
        logic                  wr;
        logic [`WP_ADDR_W-1:0] addr;
        logic [3:0]            be;
        logic [`WP_PROT_W-1:0] prot;
        logic [`WP_EVT_W-1:0]  irq_status;
        logic [`WP_EVT_W-1:0]  irq_enable;
        logic [`WP_DATA_W-1:0] hrdata;
        logic                  access_error;
        logic                  reg_error;
    } state_t;

endpackage

`default_nettype wire

//--- hw/bridge_b_write_protect_regs.sv
/*
 * Write-protect control for one peripheral bridge instance: clear and set
 * registers over AHB-Lite, a write guard for six peripherals, and sticky
 * error events with one level interrupt.
 * Assumes a single clock, a synchronous active-high reset, guard requests
 * from logic on the same clock, and a master doing single transfers.
 */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "bridge_b_wp_params.svh"

module bridge_b_write_protect_regs (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    input  wire bridge_b_wp_pkg::guard_req_t guard_req,
    output logic [`WP_PROT_W-1:0]           guard_grant,
    output logic [`WP_PROT_W-1:0]           protect_state,
    output logic                            access_error,
    output logic                            reg_error,
    output logic                            irq
);

    localparam logic [`WP_PROT_W-1:0] PROT_IMPL = `WP_PROT_IMPL;

    bridge_b_wp_pkg::state_t st;
    bridge_b_wp_pkg::state_t next_st;

    // Byte lanes of a transfer from its size and low address bits
    function automatic logic [3:0] lanes(input logic [2:0] size,
                                         input logic [1:0] low);
        logic [3:0] be;
        be = 4'hf;
        case (size)
            `WP_HSIZE_BYTE: be = 4'h1 << low;
            `WP_HSIZE_HALF: be = low[1] ? 4'hc : 4'h3;
            default:        be = 4'hf;
        endcase
        return be;
    endfunction

    // Byte lanes widened to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // Register read view; both protection registers show one state
    function automatic logic [31:0] read_view(
            input logic [`WP_ADDR_W-1:0] a,
            input bridge_b_wp_pkg::state_t s);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            `WP_OFS_CLEAR:      d = 32'(s.prot & PROT_IMPL);
            `WP_OFS_SET:        d = 32'(s.prot & PROT_IMPL);
            `WP_OFS_IRQ_STATUS: d = 32'(s.irq_status);
            `WP_OFS_IRQ_ENABLE: d = 32'(s.irq_enable);
            default:            d = 32'h0;
        endcase
        return d;
    endfunction

    logic [31:0]            wmask;
    logic [31:0]            wval;
    logic [`WP_PROT_W-1:0]  hits;
    logic [`WP_PROT_W-1:0]  blocked_vec;
    logic [`WP_EVT_W-1:0]   evt;
    logic [`WP_EVT_W-1:0]   evt_clr;
    logic                   take;

    always_comb begin
        next_st = st;
        next_st.access_error = 1'b0;
        next_st.reg_error = 1'b0;
        wmask = lane_mask(st.be);
        wval = hwdata & wmask;
        // Only implemented positions take part; zeros never act
        hits = wval[`WP_PROT_W-1:0] & PROT_IMPL;
        evt = '0;
        evt_clr = '0;

        // Data phase of a write
        if (st.data_phase && st.wr) begin
            case (st.addr)
                `WP_OFS_CLEAR: begin
                    next_st.prot = st.prot & ~hits;
                    if ((hits & ~st.prot) != '0) begin
                        evt[`WP_EVT_DOUBLE_CLR] = 1'b1;
                    end
                end
                `WP_OFS_SET: begin
                    next_st.prot = st.prot | hits;
                    if ((hits & st.prot) != '0) begin
                        evt[`WP_EVT_DOUBLE_SET] = 1'b1;
                    end
                end
                `WP_OFS_IRQ_CLEAR: begin
                    evt_clr = wval[`WP_EVT_W-1:0];
                end
                `WP_OFS_IRQ_ENABLE: begin
                    if (st.be[0]) begin
                        next_st.irq_enable = hwdata[`WP_EVT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Guarded writes; the debugger bypasses protection
        blocked_vec = guard_req.write & st.prot & PROT_IMPL;
        if (guard_req.debug) begin
            blocked_vec = '0;
        end
        if (blocked_vec != '0) begin
            evt[`WP_EVT_BLOCKED] = 1'b1;
        end

        next_st.access_error = evt[`WP_EVT_BLOCKED];
        next_st.reg_error = evt[`WP_EVT_DOUBLE_SET] | evt[`WP_EVT_DOUBLE_CLR];
        // New event wins over a clear in the same cycle
        next_st.irq_status = (st.irq_status & ~evt_clr) | evt;

        // Address phase
        take = hsel && htrans[1] && hready;
        next_st.data_phase = take;
        if (take) begin
            next_st.wr = hwrite;
            next_st.addr = {haddr[`WP_ADDR_W-1:2], 2'b00};
            next_st.be = lanes(hsize, haddr[1:0]);
            if (!hwrite) begin
                // Read sees any write finishing in this same cycle
                next_st.hrdata = read_view(next_st.addr, next_st);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st.data_phase <= 1'b0;
            st.wr <= 1'b0;
            st.addr <= '0;
            st.be <= 4'h0;
            st.prot <= `WP_PROT_RESET;
            st.irq_status <= `WP_EVT_RESET;
            st.irq_enable <= `WP_EVT_RESET;
            st.hrdata <= 32'h0;
            st.access_error <= 1'b0;
            st.reg_error <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Positions: trace 6, USB 5, DMA 4, I/O port 3, flash 2, debug unit 1
    assign guard_grant = guard_req.write &
        ((~st.prot) | {`WP_PROT_W{guard_req.debug}});
    assign protect_state = st.prot & PROT_IMPL;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign access_error = st.access_error;
    assign reg_error = st.reg_error;
    assign irq = |(st.irq_status & st.irq_enable);

endmodule // bridge_b_write_protect_regs

`default_nettype wire

//--- verification/wp_assertions.sv
/* Checker on the write-protect block ports.
   Assumes full-word single writes on the register bus. */
`timescale 1ns/1ps
`default_nettype none
module wp_assertions (
    input wire logic                        clock,
    input wire logic                        rst,
    input wire logic                        hsel,
    input wire logic [31:0]                 haddr,
    input wire logic [1:0]                  htrans,
    input wire logic                        hwrite,
    input wire logic [31:0]                 hwdata,
    input wire logic                        hready,
    input wire bridge_b_wp_pkg::guard_req_t guard_req,
    input wire logic [6:0]                  guard_grant,
    input wire logic [6:0]                  protect_state,
    input wire logic                        access_error,
    input wire logic                        reg_error
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic taken = hsel && htrans[1] && hready && hwrite;
    wire logic blk = |(guard_req.write & protect_state) && !guard_req.debug;
    sequence set_twice;
        taken && haddr[11:2] == 10'h001 ##1 |(hwdata[6:1] & protect_state[6:1]);
    endsequence
    sequence clr_twice;
        taken && haddr[11:2] == 10'h000 ##1 |(hwdata[6:1] & ~protect_state[6:1]);
    endsequence
    AST_RESET_VALUE: assert property ($fell(rst) |-> protect_state == 7'h02)
        else $error("reset value");
    AST_BIT0_ZERO: assert property (protect_state[0] == 1'b0)
        else $error("bit 0 set");
    AST_GRANT: assert property (guard_grant == (guard_req.write &
        (~protect_state | {7{guard_req.debug}}))) else $error("grant");
    AST_BLOCK_ERR: assert property (blk |=> access_error)
        else $error("no access error");
    AST_NO_FALSE_ERR: assert property (!blk |=> !access_error)
        else $error("false access error");
    AST_HOLD: assert property (!$stable(protect_state) && !$past(rst)
        |-> $past(taken, 2)) else $error("state moved");
    AST_DOUBLE_SET: assert property (set_twice |=> reg_error)
        else $error("double set");
    AST_DOUBLE_CLR: assert property (clr_twice |=> reg_error)
        else $error("double clear");
endmodule // wp_assertions
bind bridge_b_write_protect_regs wp_assertions u_wp_chk (.clock(clock),
    .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .guard_req(guard_req),
    .guard_grant(guard_grant), .protect_state(protect_state),
    .access_error(access_error), .reg_error(reg_error));
`default_nettype wire

//--- verification/ahb_host.sv
/* Bus master model of the processor core.
   Assumes task calls start just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
    input  wire logic        clock,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
    end
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
    endtask
endmodule // ahb_host
`default_nettype wire

//--- verification/tb.sv
/* Self-checking bench of the write-protect block.
   Assumes the host model drives the register bus. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    err_total++; $display("BAD %0t %h %h", $time, a, b); end end
module tb;
    logic                        clock, rst, hsel, hwrite, hreadyout;
    logic                        hresp, access_error, reg_error, irq;
    logic [31:0]                 haddr, hwdata, hrdata, rd, exp;
    logic [1:0]                  htrans;
    logic [2:0]                  hsize;
    logic [6:0]                  guard_grant, protect_state;
    bridge_b_wp_pkg::guard_req_t guard_req;
    int                          err_total = 0;
    int                          total_checks = 0;
    ahb_host host (.clock(clock), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    bridge_b_write_protect_regs dut (.clock(clock), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .guard_req(guard_req),
        .guard_grant(guard_grant), .protect_state(protect_state),
        .access_error(access_error), .reg_error(reg_error), .irq(irq));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic stop_test;
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, d);
        host.xfer(1'b1, a, d, rd);
    endtask
    task automatic rd_chk(input logic [31:0] a, e);
        host.xfer(1'b0, a, 32'h0, rd);
        `CHK(rd, e)
    endtask
    task automatic t_reset;
        rd_chk(32'h0, 32'h2);
        rd_chk(32'h4, 32'h2);
        rd_chk(32'h40, 32'h0);
        `CHK(protect_state, 7'h02)
        `CHK(hresp, 1'b0)
    endtask
    task automatic t_set_clear;
        exp = 32'h2;
        for (int b = 2; b <= 6; b++) begin
            wr(32'h4, 32'h1 << b);
            exp |= 32'h1 << b;
            rd_chk(32'h0, exp);
            `CHK(protect_state, exp[6:0])
        end
        wr(32'h4, 32'hffffff81);
        wr(32'h0, 32'hffffff81);
        rd_chk(32'h4, 32'h7e);
        for (int b = 6; b >= 2; b--) begin
            wr(32'h0, 32'h1 << b);
            exp &= ~(32'h1 << b);
            rd_chk(32'h4, exp);
        end
    endtask
    task automatic t_double;
        wr(32'h4, 32'h2);
        #1 `CHK(reg_error, 1'b1)
        wr(32'h0, 32'h8);
        #1 `CHK(reg_error, 1'b1)
        rd_chk(32'h8, 32'h3);
        `CHK(irq, 1'b0)
        wr(32'h10, 32'h3);
        #1 `CHK(irq, 1'b1)
        wr(32'hc, 32'h3);
        #1 `CHK(irq, 1'b0)
    endtask
    task automatic t_guard;
        wr(32'h4, 32'h10);
        guard_req <= {7'h30, 1'b0};
        #1 `CHK(guard_grant, 7'h20)
        @(posedge clock);
        guard_req <= {7'h30, 1'b1};
        #1 `CHK(access_error, 1'b1)
        `CHK(guard_grant, 7'h30)
        @(posedge clock);
        guard_req <= '0;
        #1 `CHK(access_error, 1'b0)
        rd_chk(32'h8, 32'h4);
    endtask
    initial begin
        rst = 1'b1;
        guard_req = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset;
        t_set_clear;
        t_double;
        t_guard;
        stop_test;
    end
    initial begin
        repeat (2000) @(posedge clock);
        err_total++;
        stop_test;
    end
endmodule // tb
`default_nettype wire
